/* File: core/clock_ctl_defs.svh */
// Constants of the main clock controller: register indices, reset values,
// writable-bit masks and timing figures.
// Assumes it is included by its bare name ahead of the package and the module.
`ifndef CLOCK_CTL_DEFS_SVH
`define CLOCK_CTL_DEFS_SVH

// Register indices; the byte address on the bus is four times the index
`define CLK_IDX_CONTROL      6'h00
`define CLK_IDX_INT_EN_CLR   6'h01
`define CLK_IDX_INT_EN_SET   6'h02
`define CLK_IDX_INT_FLAGS    6'h03
`define CLK_IDX_HS_DIV       6'h04
`define CLK_IDX_CPU_DIV      6'h05
`define CLK_IDX_AHB_GATES    6'h10
`define CLK_IDX_APB_A_GATES  6'h14
`define CLK_IDX_APB_B_GATES  6'h18

// Field positions
`define CLK_READY_BIT        0
`define CLK_BYTE_W           8

// Reset and fixed values
`define CLK_RST_INT_EN       1'b0
`define CLK_RST_FLAGS        1'b1
`define CLK_HS_DIV_VALUE     8'h01
`define CLK_RST_CPU_DIV      8'h01
`define CLK_RST_AHB          32'h00ffffff
`define CLK_RST_APB_A        32'h000000ff
`define CLK_RST_APB_B        32'h00018056

// Bits that software may change; all others hold their reset value
`define CLK_WMASK_AHB        32'h00fff75f
`define CLK_WMASK_APB_A      32'h0000ffff
`define CLK_WMASK_APB_B      32'h00017e97

// Settling time of a divider change, and the mclk period it is counted in
`define CLK_SETTLE_NS        40
`define CLK_MCLK_PERIOD_NS   10

`endif

/* File: core/clock_ctl_pkg.sv */
// Types shared by the main clock controller and its bench.
// Assumes clock_ctl_defs.svh holds the numeric constants.
package clock_ctl_pkg;

    typedef struct packed {
        logic [7:0]  adr;
        logic        we;
        logic [3:0]  sel;
        logic [31:0] dat;
    } wb_req_t;

    typedef struct packed {
        logic [31:0] ahb;
        logic [31:0] apb_a;
        logic [31:0] apb_b;
    } clock_gates_t;

    typedef enum logic [0:0] {
        SETTLE_IDLE = 1'b0,
        SETTLE_BUSY = 1'b1
    } settle_state_t;

endpackage

/* File: core/main_clock_ctl.sv */
// Main clock controller: CPU clock divider, clock-ready flag with interrupt,
// and the AHB / APB-A / APB-B peripheral clock gates, on a Wishbone slave.
// Assumes a classic Wishbone master on mclk and a write-protect level from
// the access protection unit on the same clock.
`timescale 1ns/1ps
`include "clock_ctl_defs.svh"

// Contract
// - Byte, halfword and word accesses, each byte lane reachable on its own.
// - Writes to protected registers are blocked while protection is on.
// - Writing one to enable-clear bit 0 clears enable and request.
// - Writing one to enable-set bit 0 sets enable; both reset to zero.
// - Enable-set and enable-clear read back the same single enable bit.
// - Clock-ready flag resets to one and sets when clocks are settled.
// - Writing one clears the clock-ready flag; zero is ignored.
// - High-speed divider reads fixed divide-by-one, read-only.
// - CPU divider is 8-bit, resets to one, one-hot codes divide 1..128.
// - Each AHB gate bit stops its clock at zero; reset all 24 ones.
// - AHB bits 0-10 gate bridges, debug, flash, cache, DMA, USB.
// - AHB bits 12-23 gate protection through flash cache, in order.
// - AHB bits 11, 7, 5 are read-only ones; software writes them one.
// - APB-A gates reset to 0xff; bits 0-7 gate system units.
// - APB-A bits 8-15 gate watchdog through timer 1; zero stops.
// - APB-B gates reset to 0x18056; bits 0,1,2,4,7 gate listed units.
// - APB-B bits 9-14 gate serial units and timers, bit 16 RAM ECC.
// - Forbidden divider is stored but unused, and a violation is reported.
// - Flag reads zero while settling; rewriting then is a violation.
// - Interrupt holds while flag and enable are both set.
// - A gated-off peripheral is unreachable until its bit is set again.
module main_clock_ctl
    import clock_ctl_pkg::*;
#(
    parameter int SETTLE_CYCLES =
        (`CLK_SETTLE_NS + `CLK_MCLK_PERIOD_NS - 1) / `CLK_MCLK_PERIOD_NS
) (
    input  wire logic         mclk,
    input  wire logic         sys_rst,
    input  wire logic         wb_cyc_i,
    input  wire logic         wb_stb_i,
    input  wire logic         wb_we_i,
    input  wire logic [7:0]   wb_adr_i,
    input  wire logic [3:0]   wb_sel_i,
    input  wire logic [31:0]  wb_dat_i,
    output logic      [31:0]  wb_dat_o,
    output logic              wb_ack_o,
    input  wire logic         write_protect,
    output logic              irq,
    output logic              protect_violation,
    output logic              cpu_tick,
    output logic      [7:0]   cpu_div_active,
    output clock_gates_t      clock_gates
);

    // Settling counter is eight bits and must count at least one edge
    if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > 255) begin : g_bad_settle
        $error("SETTLE_CYCLES must lie in 1..255");
    end

    localparam logic [7:0] SETTLE_LOAD = 8'(SETTLE_CYCLES - 1);

    // Bus request bundle
    wb_req_t     req;
    assign req = '{adr: wb_adr_i,
                   we:  wb_we_i,
                   sel: wb_sel_i,
                   dat: wb_dat_i};

    // Registers
    logic          int_enable;
    logic          clock_ready;
    logic [7:0]    cpu_divider;
    logic [31:0]   ahb_gates;
    logic [31:0]   apb_a_gates;
    logic [31:0]   apb_b_gates;
    logic [7:0]    settle_count;
    logic [7:0]    div_count;
    settle_state_t settle_state;

    // Address decode
    wire        take      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire [5:0]  word_idx  = req.adr[7:2];
    wire        hit_ctrl  = (word_idx == `CLK_IDX_CONTROL);
    wire        hit_clr   = (word_idx == `CLK_IDX_INT_EN_CLR);
    wire        hit_set   = (word_idx == `CLK_IDX_INT_EN_SET);
    wire        hit_flags = (word_idx == `CLK_IDX_INT_FLAGS);
    wire        hit_hs    = (word_idx == `CLK_IDX_HS_DIV);
    wire        hit_cpu   = (word_idx == `CLK_IDX_CPU_DIV);
    wire        hit_ahb   = (word_idx == `CLK_IDX_AHB_GATES);
    wire        hit_apb_a = (word_idx == `CLK_IDX_APB_A_GATES);
    wire        hit_apb_b = (word_idx == `CLK_IDX_APB_B_GATES);
    // Control, enable, CPU divider and gate registers carry write protection; the flag and high-speed divider do not
    wire        hit_prot  = hit_ctrl | hit_clr | hit_set | hit_cpu
                          | hit_ahb | hit_apb_a | hit_apb_b;

    logic [31:0] lane_mask;
    for (genvar b = 0; b < 4; b++) begin : g_lane
        assign lane_mask[b*`CLK_BYTE_W +: `CLK_BYTE_W] = {`CLK_BYTE_W{req.sel[b]}};
    end
    wire        wr_any    = take & req.we;
    wire        wr_ok     = wr_any & ~write_protect;
    wire        blocked   = wr_any & write_protect & hit_prot;
    wire        bit0_one  = req.sel[0] & req.dat[`CLK_READY_BIT];

    wire        en_set    = wr_ok & hit_set & bit0_one;
    wire        en_clr    = wr_ok & hit_clr & bit0_one;
    wire        next_int_enable = en_set ? 1'b1 : (en_clr ? 1'b0 : int_enable);

    // CPU divider write handling
    wire        settling  = (settle_state == SETTLE_BUSY);
    wire        div_write = wr_ok & hit_cpu & req.sel[0];
    wire [7:0]  div_value = req.dat[7:0];
    wire        div_refused = div_write & settling;
    wire        div_store   = div_write & ~settling;
    // one-hot and not below the high-speed divider
    wire        div_legal   = (div_value != 8'h00)
                            && ((div_value & (div_value - 8'h01)) == 8'h00)
                            && (div_value >= `CLK_HS_DIV_VALUE);
    wire        div_start   = div_store & div_legal;
    wire        div_illegal = div_store & ~div_legal;
    wire        settle_done = settling & (settle_count == 8'h00);

    wire        flag_clr  = wr_any & hit_flags & bit0_one;
    // set on settle; set wins over a same-cycle clear
    wire        next_clock_ready = settle_done ? 1'b1
                                 : ((div_start | flag_clr) ? 1'b0 : clock_ready);
    wire        next_irq  = next_clock_ready & next_int_enable;

    // Gate writes per byte lane; read-only bits keep their reset value
    wire        wr_ahb    = wr_ok & hit_ahb;
    wire        wr_apb_a  = wr_ok & hit_apb_a;
    wire        wr_apb_b  = wr_ok & hit_apb_b;

    // Divider: one-hot code equals the ratio, so it is the period directly
    wire [7:0]  div_last  = cpu_div_active - 8'h01;
    // Restart on a new ratio so the first period after a change is whole
    wire [7:0]  next_div_count = (settle_done || div_count >= div_last) ? 8'h00
                               : div_count + 8'h01;

    // Read data; control reads zero, shared enable, fixed divider
    logic [31:0] rd_data;
    always_comb begin
        if (hit_clr) begin
            rd_data = {31'h0, int_enable};
        end else if (hit_set) begin
            rd_data = {31'h0, int_enable};
        end else if (hit_flags) begin
            rd_data = {31'h0, clock_ready};
        end else if (hit_hs) begin
            rd_data = {24'h0, `CLK_HS_DIV_VALUE};
        end else if (hit_cpu) begin
            rd_data = {24'h0, cpu_divider};
        end else if (hit_ahb) begin
            rd_data = ahb_gates;
        end else if (hit_apb_a) begin
            rd_data = apb_a_gates;
        end else if (hit_apb_b) begin
            rd_data = apb_b_gates;
        end else begin
            rd_data = 32'h0;
        end
    end

    // Bus answer one cycle after the request is taken
    // Ack drops on its own, so a strobe held too long is taken again
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= take;
        end
    end

    // Read data stands only with the ack, zero otherwise
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            wb_dat_o <= 32'h0;
        end else begin
            wb_dat_o <= (take & ~req.we) ? rd_data : 32'h0;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            int_enable <= `CLK_RST_INT_EN;
        end else begin
            int_enable <= next_int_enable;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            clock_ready <= `CLK_RST_FLAGS;
        end else begin
            clock_ready <= next_clock_ready;
        end
    end

    // request registered from the same next values as flag and enable
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            irq <= 1'b0;
        end else begin
            irq <= next_irq;
        end
    end

    // stored divider code, lane 0 only
    lane_register #(
        .WIDTH (8),
        .RESET (`CLK_RST_CPU_DIV),
        .WMASK (8'hff)
    ) cpu_divider_i (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .write   (div_store),
        .lanes   (8'hff),
        .data    (div_value),
        .value   (cpu_divider)
    );

    // Settling of a new division; the active ratio changes only at the end
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            settle_state   <= SETTLE_IDLE;
            settle_count   <= 8'h00;
        end else begin
            case (settle_state)
                SETTLE_IDLE: begin
                    if (div_start) begin
                        settle_state <= SETTLE_BUSY;
                        settle_count <= SETTLE_LOAD;
                    end
                end
                SETTLE_BUSY: begin
                    if (settle_done) begin
                        settle_state   <= SETTLE_IDLE;
                    end else begin
                        settle_count <= settle_count - 8'h01;
                    end
                end
                default: settle_state <= SETTLE_IDLE;
            endcase
        end
    end

    // active ratio follows the stored code only at the end of settling
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            cpu_div_active <= `CLK_RST_CPU_DIV;
        end else if (settle_done) begin
            cpu_div_active <= cpu_divider;
        end
    end

    // CPU clock prescaler count
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            div_count <= 8'h00;
        end else begin
            div_count <= next_div_count;
        end
    end

    // Tick is registered from the next count, so it lines up with count zero
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            cpu_tick <= 1'b1;
        end else begin
            cpu_tick <= (next_div_count == 8'h00);
        end
    end

    lane_register #(
        .WIDTH (32),
        .RESET (`CLK_RST_AHB),
        .WMASK (`CLK_WMASK_AHB)
    ) ahb_gates_i (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .write   (wr_ahb),
        .lanes   (lane_mask),
        .data    (req.dat),
        .value   (ahb_gates)
    );

    lane_register #(
        .WIDTH (32),
        .RESET (`CLK_RST_APB_A),
        .WMASK (`CLK_WMASK_APB_A)
    ) apb_a_gates_i (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .write   (wr_apb_a),
        .lanes   (lane_mask),
        .data    (req.dat),
        .value   (apb_a_gates)
    );

    lane_register #(
        .WIDTH (32),
        .RESET (`CLK_RST_APB_B),
        .WMASK (`CLK_WMASK_APB_B)
    ) apb_b_gates_i (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .write   (wr_apb_b),
        .lanes   (lane_mask),
        .data    (req.dat),
        .value   (apb_b_gates)
    );

    // gates drive the peripheral clock enables
    // Masking off this block's own bus clock locks the gates until reset
    assign clock_gates = '{ahb: ahb_gates, apb_a: apb_a_gates, apb_b: apb_b_gates};

    // Violations to the access protection unit, one-cycle pulse
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            protect_violation <= 1'b0;
        end else begin
            protect_violation <= blocked | div_refused | div_illegal;
        end
    end

endmodule // main_clock_ctl


// Byte-lane register; bits outside the writable mask hold their reset value
module lane_register #(
    parameter int               WIDTH = 32,
    parameter logic [WIDTH-1:0] RESET = '0,
    parameter logic [WIDTH-1:0] WMASK = '1
) (
    input  wire logic             mclk,
    input  wire logic             sys_rst,
    input  wire logic             write,
    input  wire logic [WIDTH-1:0] lanes,
    input  wire logic [WIDTH-1:0] data,
    output logic      [WIDTH-1:0] value
);

    if (WIDTH < 1) begin : g_bad_width
        $error("WIDTH must be at least 1");
    end

    // Read-only bits are never written, so a stray write cannot clear them
    wire [WIDTH-1:0] change     = lanes & WMASK;
    wire [WIDTH-1:0] next_value = write ? ((value & ~change) | (data & change)) : value;

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            value <= RESET;
        end else begin
            value <= next_value;
        end
    end

endmodule // lane_register

/* File: test/main_clock_ctl_checker.sv */
// Port checker for the main clock controller.
// Assumes a single mclk domain and sys_rst active high.
`timescale 1ns/1ps
module main_clock_ctl_checker
    import clock_ctl_pkg::*;
(
    input  wire logic         mclk,
    input  wire logic         sys_rst,
    input  wire logic         wb_cyc_i,
    input  wire logic         wb_stb_i,
    input  wire logic         wb_we_i,
    input  wire logic [7:0]   wb_adr_i,
    input  wire logic [3:0]   wb_sel_i,
    input  wire logic [31:0]  wb_dat_i,
    input  wire logic [31:0]  wb_dat_o,
    input  wire logic         wb_ack_o,
    input  wire logic         write_protect,
    input  wire logic         irq,
    input  wire logic         protect_violation,
    input  wire logic         cpu_tick,
    input  wire logic [7:0]   cpu_div_active,
    input  wire clock_gates_t clock_gates
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    wire take    = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire rd_take = take && !wb_we_i;
    wire gate_wr = take && wb_we_i && (wb_adr_i[7:4] inside {4'h4, 4'h5, 4'h6});
    a_ack_answer: assert property (take |=> wb_ack_o) else $error("no ack");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("long ack");
    a_control_zero: assert property (rd_take && wb_adr_i[7:2] == 6'h00 |=> wb_dat_o == 32'h0)
        else $error("control not zero");
    a_hs_div_fixed: assert property (rd_take && wb_adr_i[7:2] == 6'h04 |=> wb_dat_o[7:0] == 8'h01)
        else $error("hs divider wrong");
    a_clear_drops_irq: assert property (take && wb_we_i && wb_adr_i[7:2] == 6'h01 && wb_sel_i[0]
        && wb_dat_i[0] && !write_protect |=> !irq) else $error("irq held");
    a_protect_blocks: assert property (gate_wr && write_protect
        |=> $stable(clock_gates) && protect_violation) else $error("protected write passed");
    a_ahb_reserved: assert property (clock_gates.ahb[31:24] == 8'h00 && clock_gates.ahb[11]
        && clock_gates.ahb[7] && clock_gates.ahb[5]) else $error("reserved gate bits");
    a_div_legal: assert property ($onehot(cpu_div_active)) else $error("bad divider");
    a_tick_div1: assert property (cpu_div_active == 8'h01 |-> cpu_tick) else $error("tick");
    cover property (irq);
    cover property (protect_violation);
    cover property (cpu_div_active == 8'h80);
endmodule // main_clock_ctl_checker

bind main_clock_ctl main_clock_ctl_checker main_clock_ctl_checker_i (
    .mclk(mclk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .write_protect(write_protect), .irq(irq),
    .protect_violation(protect_violation), .cpu_tick(cpu_tick),
    .cpu_div_active(cpu_div_active), .clock_gates(clock_gates));

/* File: test/access_guard_model.sv */
// Model of the access protection unit beside the clock controller.
// Assumes the bench changes guard_on only between bus cycles.
`timescale 1ns/1ps
module access_guard_model (
    input  wire logic       mclk,
    input  wire logic       sys_rst,
    input  wire logic       guard_on,
    input  wire logic       protect_violation,
    output logic            write_protect,
    output logic [7:0]      violations
);
    assign write_protect = guard_on;
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst)
            violations <= 8'h00;
        else if (protect_violation)
            violations <= violations + 8'h01;
    end
endmodule // access_guard_model

/* File: test/main_clock_divider_and_gating_test.sv */
// Self-checking bench for the main clock controller.
// Assumes the access guard model and the bound port checker.
`timescale 1ns/1ps
`include "clock_ctl_defs.svh"
module main_clock_divider_and_gating_test import clock_ctl_pkg::*;;
    // Long enough that a refused write and a flag read land while settling
    localparam int SETTLE = 12;
    logic         mclk = 1'b0, sys_rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, guard_on = 1'b0;
    logic [7:0]   adr = 8'h00;
    logic [3:0]   sel = 4'h0, s;
    logic [31:0]  dat = 32'h0, q, d, old [3];
    wire          ack, write_protect, irq, viol, tick;
    wire  [31:0]  rdat;
    wire  [7:0]   div_act, n_viol;
    clock_gates_t gates;
    int           mismatches = 0, n_checks = 0, seed = 32'h0faf, ticks, k;
    logic [7:0]   adrs [10] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h40, 8'h50, 8'h60, 8'h70};
    logic [31:0]  rsts [10] = '{32'h0, 32'h0, 32'h0, 32'h1, 32'h1, 32'h1,
                                `CLK_RST_AHB, `CLK_RST_APB_A, `CLK_RST_APB_B, 32'h0};
    logic [7:0]   gadr [3] = '{8'h40, 8'h50, 8'h60};
    logic [31:0]  gmask [3] = '{`CLK_WMASK_AHB, `CLK_WMASK_APB_A, `CLK_WMASK_APB_B};

    always #5 mclk = ~mclk;

    main_clock_ctl #(.SETTLE_CYCLES(SETTLE)) main_clock_ctl_i (
        .mclk(mclk), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .write_protect(write_protect), .irq(irq), .protect_violation(viol),
        .cpu_tick(tick), .cpu_div_active(div_act), .clock_gates(gates));
    access_guard_model access_guard_model_i (.mclk(mclk), .sys_rst(sys_rst),
        .guard_on(guard_on), .protect_violation(viol), .write_protect(write_protect),
        .violations(n_viol));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Holds the request until ack is sampled; no latency is assumed
    task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] sl,
                      input logic [31:0] dt);
        @(posedge mclk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= sl;
        dat <= dt;
        do begin
            @(posedge mclk);
        end while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    function automatic logic [31:0] merge(input logic [31:0] o, dv, m, input logic [3:0] sl);
        logic [31:0] lm;
        lm = {{8{sl[3]}}, {8{sl[2]}}, {8{sl[1]}}, {8{sl[0]}}};
        return (o & ~(m & lm)) | (dv & m & lm);
    endfunction

    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        #400000;
        mismatches++;
        end_sim();
    end

    initial begin
        repeat (12) @(posedge mclk);
        sys_rst <= 1'b0;
        wb(1'b1, 8'h00, 4'hf, 32'hffffffff);
        wb(1'b1, 8'h10, 4'hf, 32'hffffffff);
        wb(1'b1, 8'h70, 4'hf, 32'hffffffff);
        for (int i = 0; i < 10; i++) begin
            wb(1'b0, adrs[i], 4'hf, 32'h0);
            chk(q, rsts[i]);
        end
        $display("done: reset values");
        old = '{`CLK_RST_AHB, `CLK_RST_APB_A, `CLK_RST_APB_B};
        for (int i = 0; i < 30; i++) begin
            k = i % 3;
            d = (i < 3) ? 32'h0 : $random(seed);
            s = (i < 3) ? 4'hf : 4'($random(seed));
            // reserved bits written at their reset value
            d = (d & gmask[k]) | (rsts[6 + k] & ~gmask[k]);
            wb(1'b1, gadr[k], s, d);
            old[k] = merge(old[k], d, gmask[k], s);
            wb(1'b0, gadr[k], 4'hf, 32'h0);
            chk(q, old[k]);
            chk(gates[95 - 32 * k -: 32], old[k]);
        end
        $display("done: clock gates");
        wb(1'b1, 8'h08, 4'h1, 32'h1);
        wb(1'b0, 8'h04, 4'h1, 32'h0);
        chk(q, 32'h1);
        chk({31'h0, irq}, 32'h1);
        wb(1'b1, 8'h0c, 4'h1, 32'h0);
        chk({31'h0, irq}, 32'h1);
        wb(1'b1, 8'h0c, 4'h1, 32'h1);
        chk({31'h0, irq}, 32'h0);
        $display("done: interrupt flag");
        for (int j = 7; j >= 0; j--) begin
            wb(1'b1, 8'h14, 4'h1, 32'(1 << j));
            if (j == 7) begin
                wb(1'b1, 8'h14, 4'h1, 32'h2);
                wb(1'b0, 8'h0c, 4'h1, 32'h0);
                chk(q, 32'h0);
            end
            repeat (SETTLE + 2) @(posedge mclk);
            chk({24'h0, div_act}, 32'(1 << j));
            ticks = 0;
            repeat (256) begin
                @(posedge mclk);
                ticks += int'(tick);
            end
            chk(32'(ticks), 32'(256 >> j));
        end
        chk({24'h0, n_viol}, 32'h1);
        chk({31'h0, irq}, 32'h1);
        wb(1'b1, 8'h04, 4'h1, 32'h1);
        chk({31'h0, irq}, 32'h0);
        wb(1'b0, 8'h08, 4'h1, 32'h0);
        chk(q, 32'h0);
        wb(1'b1, 8'h14, 4'h1, 32'h3);
        wb(1'b0, 8'h14, 4'h1, 32'h0);
        chk(q, 32'h3);
        chk({24'h0, div_act}, 32'h1);
        chk({24'h0, n_viol}, 32'h2);
        $display("done: divider");
        guard_on <= 1'b1;
        wb(1'b1, 8'h50, 4'hf, 32'h0);
        chk(gates.apb_a, old[1]);
        guard_on <= 1'b0;
        @(posedge mclk);
        chk({24'h0, n_viol}, 32'h3);
        $display("done: protection");
        end_sim();
    end
endmodule // main_clock_divider_and_gating_test
